// ==== flag_bank_top.sv ====
// Function
// [RULE1] Clock switch ready sets bit 6
// [RULE2] Clock switch flag never requests wake
// [RULE3] Converter threshold event sets bit 1
// [RULE4] Conversion done sets bit 0
// [RULE5] Voltage detect event sets bit 7
// [RULE6] Zero cross output change sets bit 6
// [RULE7] Comparator output change sets bits 0,1
// [RULE8] Receive flags follow buffer full, read-only
// [RULE9] Transmit flags follow buffer empty, read-only
// [RULE10] Bus collision sets bits 1 and 3
// [RULE11] Sync port completion sets bits 0,2
// [RULE12] Short timer period match sets 5,3,1
// [RULE13] Long timer overflow sets 4,2,0
// [RULE14] Eight logic cell flags at 4..7
// [RULE15] Long timer gate events set 2,1,0
// [RULE16] Capture mode capture sets unit flag
// [RULE17] Compare mode match sets unit flag
// [RULE18] PWM mode leaves unit flag unused
// [RULE19] Flags set regardless of any enable
// [RULE20] Set beats simultaneous software clear
//
// Purpose: Peripheral interrupt request flag bank behind an AHB-Lite slave
// Assumes: Event inputs are synchronous single-cycle pulses; detector outputs are pins
// Notes:   Writing one to a read/write flag leaves it, writing zero clears it
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module flag_bank_top (
    // Clock and reset
    input  wire logic                         SYS_CLK,
    input  wire logic                         RST_N,
    // AHB-Lite slave
    input  wire logic                         HSEL,
    input  wire logic [31:0]                  HADDR,
    input  wire logic [1:0]                   HTRANS,
    input  wire logic                         HWRITE,
    input  wire logic [2:0]                   HSIZE,
    input  wire logic [31:0]                  HWDATA,
    input  wire logic                         HREADY,
    output      logic [31:0]                  HRDATA,
    output      logic                         HREADYOUT,
    output      logic                         HRESP,
    // Peripheral events
    input  wire flag_bank_pkg::events_s       EVENTS,
    input  wire flag_bank_pkg::async_state_s  ASYNC_STATE,
    input  wire flag_bank_pkg::capcomp_mode_e CAPCOMP_ONE_MODE,
    input  wire flag_bank_pkg::capcomp_mode_e CAPCOMP_TWO_MODE,
    // Asynchronous detector outputs
    input  wire logic                         ZERO_CROSS_PIN,
    input  wire logic [1:0]                   COMPARATOR_PIN,
    // Buffer access strobes to the async serial units
    output      logic [1:0]                   ASYNC_RX_READ,
    output      logic [1:0]                   ASYNC_TX_WRITE,
    // Flag outputs
    output      flag_bank_pkg::flags_s        FLAGS,
    output      logic                         WAKE_REQUEST
);

    // ****************************************************************
    // Bus address phase capture
    // ****************************************************************
    logic        wr_q;
    logic        wr_d;
    logic        rd_q;
    logic        rd_d;
    logic [11:0] idx_q;
    logic [11:0] idx_d;
    logic        take;

    assign take  = HSEL && HREADY && HTRANS[1];
    assign wr_d  = take && HWRITE;
    assign rd_d  = take && !HWRITE;
    assign idx_d = take ? HADDR[13:2] : idx_q;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            idx_q <= 12'h0_000;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            idx_q <= idx_d;
        end
    end

    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    // ****************************************************************
    // Write decode
    // ****************************************************************
    wire wr_clock_conv = wr_q && (idx_q == flag_bank_pkg::IDX_CLOCK_CONV);
    wire wr_analog     = wr_q && (idx_q == flag_bank_pkg::IDX_ANALOG);
    wire wr_serial     = wr_q && (idx_q == flag_bank_pkg::IDX_SERIAL);
    wire wr_timer      = wr_q && (idx_q == flag_bank_pkg::IDX_TIMER);
    wire wr_cell_gate  = wr_q && (idx_q == flag_bank_pkg::IDX_CELL_GATE);
    wire wr_cell_cap   = wr_q && (idx_q == flag_bank_pkg::IDX_CELL_CAPTURE);
    wire wr_buf        = wr_q && (idx_q == flag_bank_pkg::IDX_ASYNC_BUF);
    wire rd_buf        = rd_q && (idx_q == flag_bank_pkg::IDX_ASYNC_BUF);

    wire [7:0] clr_bits = ~HWDATA[7:0];

    // Buffer window: bit 0 selects unit one, bit 1 unit two
    assign ASYNC_TX_WRITE = wr_buf ? HWDATA[1:0] : 2'b00; // [RULE9]
    assign ASYNC_RX_READ  = rd_buf ? HWDATA[1:0] : 2'b00; // [RULE8]

    // ****************************************************************
    // Detector synchronisers and change detection
    // ****************************************************************
    logic [2:0] det_meta_q;
    logic [2:0] det_sync_q;
    logic [2:0] det_prev_q;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            det_meta_q <= 3'h0;
            det_sync_q <= 3'h0;
            det_prev_q <= 3'h0;
        end else begin
            det_meta_q <= {ZERO_CROSS_PIN, COMPARATOR_PIN};
            det_sync_q <= det_meta_q;
            det_prev_q <= det_sync_q;
        end
    end

    // Prev starts at zero, so a pin high at reset reads as one change
    wire [2:0] det_change = det_sync_q ^ det_prev_q;

    // ****************************************************************
    // Set vectors, independent of any enable
    // ****************************************************************
    wire cap_one = (CAPCOMP_ONE_MODE == flag_bank_pkg::CC_CAPTURE) && EVENTS.capture_event[0];
    wire cap_two = (CAPCOMP_TWO_MODE == flag_bank_pkg::CC_CAPTURE) && EVENTS.capture_event[1];
    wire cmp_one = (CAPCOMP_ONE_MODE == flag_bank_pkg::CC_COMPARE) && EVENTS.compare_event[0];
    wire cmp_two = (CAPCOMP_TWO_MODE == flag_bank_pkg::CC_COMPARE) && EVENTS.compare_event[1];

    logic [7:0] set_clock_conv;
    logic [7:0] set_analog;
    logic [7:0] set_serial;
    logic [7:0] set_timer;
    logic [7:0] set_cell_gate;
    logic [7:0] set_cell_cap;

    always_comb begin // [RULE19]
        set_clock_conv = 8'h00;
        set_clock_conv[flag_bank_pkg::BIT_CLOCK_SWITCH] = EVENTS.clock_switch_ready; // [RULE1]
        set_clock_conv[flag_bank_pkg::BIT_CONV_THRESH]  = EVENTS.conv_threshold; // [RULE3]
        set_clock_conv[flag_bank_pkg::BIT_CONV_DONE]    = EVENTS.conv_done; // [RULE4]
        set_analog = {6'h00, det_change[1:0]}; // [RULE7]
        set_analog[flag_bank_pkg::BIT_VOLT_DETECT] = EVENTS.voltage_detect; // [RULE5]
        set_analog[flag_bank_pkg::BIT_ZERO_CROSS]  = det_change[2]; // [RULE6]
        set_serial = {4'h0, EVENTS.bus_collision[1], EVENTS.sync_port_done[1],
                      EVENTS.bus_collision[0], EVENTS.sync_port_done[0]}; // [RULE10] [RULE11]
        set_timer = {2'b00,
                     EVENTS.short_timer_match[2], EVENTS.long_timer_overflow[2],
                     EVENTS.short_timer_match[1], EVENTS.long_timer_overflow[1],
                     EVENTS.short_timer_match[0],
                     EVENTS.long_timer_overflow[0]}; // [RULE12] [RULE13]
        set_cell_gate = {EVENTS.logic_cell[3:0], 1'b0, EVENTS.long_timer_gate}; // [RULE14] [RULE15]
        set_cell_cap = {EVENTS.logic_cell[7:4], 4'h0}; // [RULE14]
        // PWM mode and off gate both events out
        set_cell_cap[flag_bank_pkg::BIT_CAPCOMP_ONE] = cap_one || cmp_one; // [RULE16] [RULE17] [RULE18]
        set_cell_cap[flag_bank_pkg::BIT_CAPCOMP_TWO] = cap_two || cmp_two; // [RULE16] [RULE17] [RULE18]
    end

    // ****************************************************************
    // Flag banks
    // ****************************************************************
    logic [7:0] f_clock_conv;
    logic [7:0] f_analog;
    logic [7:0] f_serial_rw;
    logic [7:0] f_timer;
    logic [7:0] f_cell_gate;
    logic [7:0] f_cell_cap;

    // One wide bank: every register shares the same set-wins update
    sticky_flag #(.W(48)) u_flags (
        .clk    (SYS_CLK),
        .rst_n  (RST_N),
        .set_i  ({set_clock_conv, set_analog, set_serial,
                  set_timer, set_cell_gate, set_cell_cap}),
        .clr_i  ({wr_clock_conv ? clr_bits : 8'h00, wr_analog ? clr_bits : 8'h00,
                  wr_serial ? clr_bits : 8'h00, wr_timer ? clr_bits : 8'h00,
                  wr_cell_gate ? clr_bits : 8'h00, wr_cell_cap ? clr_bits : 8'h00}),
        .mask_i ({flag_bank_pkg::MASK_CLOCK_CONV, flag_bank_pkg::MASK_ANALOG,
                  flag_bank_pkg::MASK_SERIAL_RW, flag_bank_pkg::MASK_TIMER,
                  flag_bank_pkg::MASK_CELL_GATE, flag_bank_pkg::MASK_CELL_CAP}),
        .flag_o ({f_clock_conv, f_analog, f_serial_rw, f_timer, f_cell_gate, f_cell_cap})
    );

    // ****************************************************************
    // Read-only async serial flags
    // ****************************************************************
    logic [3:0] async_q;

    // Level mirrors of the unit state; writes never touch these bits
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            async_q <= 4'h0;
        end else begin
            async_q <= {ASYNC_STATE.rx_full, ASYNC_STATE.tx_empty}; // [RULE8] [RULE9]
        end
    end

    logic [7:0] f_serial;

    always_comb begin
        f_serial = f_serial_rw;
        f_serial[flag_bank_pkg::BIT_RX_TWO] = async_q[3]; // [RULE8]
        f_serial[flag_bank_pkg::BIT_RX_ONE] = async_q[2]; // [RULE8]
        f_serial[flag_bank_pkg::BIT_TX_TWO] = async_q[1]; // [RULE9]
        f_serial[flag_bank_pkg::BIT_TX_ONE] = async_q[0]; // [RULE9]
    end

    assign FLAGS = '{clock_conv:   f_clock_conv,
                     analog:       f_analog,
                     serial:       f_serial,
                     timer:        f_timer,
                     cell_gate:    f_cell_gate,
                     cell_capture: f_cell_cap};

    // Clock switch bit is left out so it can never pull the core out of sleep
    wire [7:0] wake_clock_conv = f_clock_conv &
                                 ~(8'h01 << flag_bank_pkg::BIT_CLOCK_SWITCH); // [RULE2]
    assign WAKE_REQUEST = |{wake_clock_conv, f_analog, f_serial, f_timer,
                            f_cell_gate, f_cell_cap}; // [RULE2]

    // ****************************************************************
    // Read mux
    // ****************************************************************
    logic [7:0] rd_byte;

    always_comb begin
        case (idx_q)
            flag_bank_pkg::IDX_CLOCK_CONV:   rd_byte = f_clock_conv;
            flag_bank_pkg::IDX_ANALOG:       rd_byte = f_analog;
            flag_bank_pkg::IDX_SERIAL:       rd_byte = f_serial;
            flag_bank_pkg::IDX_TIMER:        rd_byte = f_timer;
            flag_bank_pkg::IDX_CELL_GATE:    rd_byte = f_cell_gate;
            flag_bank_pkg::IDX_CELL_CAPTURE: rd_byte = f_cell_cap;
            default:                         rd_byte = 8'h00;
        endcase
    end

    assign HRDATA = {24'h00_0000, rd_q ? rd_byte : 8'h00};

endmodule

// ==== flag_bank_pkg.sv ====
// Purpose: Shared constants and carriers for the peripheral interrupt flag bank
// Assumes: AHB-Lite register access, 32-bit data, one register per aligned word
// Notes:   Printed offsets are register indices; byte address is four times the index
package flag_bank_pkg;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [11:0] IDX_CLOCK_CONV   = 12'h0_EC6;
    localparam logic [11:0] IDX_ANALOG       = 12'h0_EC7;
    localparam logic [11:0] IDX_SERIAL       = 12'h0_EC8;
    localparam logic [11:0] IDX_TIMER        = 12'h0_EC9;
    localparam logic [11:0] IDX_CELL_GATE    = 12'h0_ECA;
    localparam logic [11:0] IDX_CELL_CAPTURE = 12'h0_ECB;
    // Buffer access strobes for the async serial units
    localparam logic [11:0] IDX_ASYNC_BUF    = 12'h0_ED0;

    // ****************************************************************
    // Reset values and implemented bit masks
    // ****************************************************************
    localparam logic [7:0] RST_FLAGS        = 8'h00;
    localparam logic [7:0] MASK_CLOCK_CONV  = 8'h43;
    localparam logic [7:0] MASK_ANALOG      = 8'hC3;
    localparam logic [7:0] MASK_SERIAL_RW   = 8'h0F;
    localparam logic [7:0] MASK_TIMER       = 8'h3F;
    localparam logic [7:0] MASK_CELL_GATE   = 8'hF7;
    localparam logic [7:0] MASK_CELL_CAP    = 8'hF3;

    // ****************************************************************
    // Bit positions
    // ****************************************************************
    localparam int BIT_CLOCK_SWITCH  = 6;
    localparam int BIT_CONV_THRESH   = 1;
    localparam int BIT_CONV_DONE     = 0;
    localparam int BIT_VOLT_DETECT   = 7;
    localparam int BIT_ZERO_CROSS    = 6;
    localparam int BIT_RX_ONE        = 5;
    localparam int BIT_RX_TWO        = 7;
    localparam int BIT_TX_ONE        = 4;
    localparam int BIT_TX_TWO        = 6;
    localparam int BIT_CAPCOMP_TWO   = 1;
    localparam int BIT_CAPCOMP_ONE   = 0;

    // ****************************************************************
    // Carriers and modes
    // ****************************************************************
    typedef enum logic [1:0] {CC_CAPTURE, CC_COMPARE, CC_PWM, CC_OFF} capcomp_mode_e;

    typedef struct packed {
        logic       clock_switch_ready;
        logic       conv_threshold;
        logic       conv_done;
        logic       voltage_detect;
        logic       zero_cross_out;
        logic [1:0] comparator_out;
        logic [1:0] bus_collision;
        logic [1:0] sync_port_done;
        logic [2:0] short_timer_match;
        logic [2:0] long_timer_overflow;
        logic [2:0] long_timer_gate;
        logic [7:0] logic_cell;
        logic [1:0] capture_event;
        logic [1:0] compare_event;
    } events_s;

    typedef struct packed {
        logic [1:0] rx_full;
        logic [1:0] tx_empty;
    } async_state_s;

    typedef struct packed {
        logic [7:0] clock_conv;
        logic [7:0] analog;
        logic [7:0] serial;
        logic [7:0] timer;
        logic [7:0] cell_gate;
        logic [7:0] cell_capture;
    } flags_s;

endpackage

// ==== sticky_flag.sv ====
// Purpose: One bank of software-cleared sticky flags
// Assumes: Set pulses are synchronous to the clock
// Notes:   A set in the clearing cycle wins
`timescale 1ns/1ps
module sticky_flag #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Control
    input  wire logic [W-1:0] set_i,
    input  wire logic [W-1:0] clr_i,
    input  wire logic [W-1:0] mask_i,
    // State
    output      logic [W-1:0] flag_o
);

    logic [W-1:0] flag_q;
    logic [W-1:0] flag_d;

    assign flag_d = ((flag_q & ~clr_i) | set_i) & mask_i; // [RULE20]
    assign flag_o = flag_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;
        end
    end

endmodule

// ==== periph_model.sv ====
// Purpose: Model of the peripherals that raise events and hold serial buffer levels
// Assumes: Strobes from the flag bank are one-cycle pulses on the system clock
// Notes:   Levels move only on request or on a buffer strobe
`timescale 1ns/1ps
module periph_model (
    // Clock
    input  wire logic                        clk,
    // Buffer strobes
    input  wire logic [1:0]                  rx_read,
    input  wire logic [1:0]                  tx_write,
    // Peripheral side
    output      flag_bank_pkg::events_s      events,
    output      flag_bank_pkg::async_state_s async_state,
    output      logic                        zero_cross,
    output      logic [1:0]                  comparator
);
    initial begin
        events = '0;
        async_state = '0;
        zero_cross = 1'b0;
        comparator = 2'b00;
    end

    // ****************************************************************
    // Serial buffers
    // ****************************************************************
    // Reading empties a full receive buffer, writing fills the transmit buffer
    always @(posedge clk) begin
        if (|{rx_read, tx_write}) begin
            async_state.rx_full <= async_state.rx_full & ~rx_read;
            async_state.tx_empty <= async_state.tx_empty & ~tx_write;
        end
    end

    task automatic pulse(input flag_bank_pkg::events_s ev);
        @(posedge clk);
        events <= ev;
        @(posedge clk);
        events <= '0;
    endtask

    task automatic set_levels(input logic [1:0] rx, input logic [1:0] tx);
        @(posedge clk);
        async_state <= {rx, tx};
    endtask

    // Detector outputs change level; either edge counts
    task automatic toggle_pins(input logic [2:0] which);
        @(posedge clk);
        {zero_cross, comparator} <= {zero_cross, comparator} ^ which;
    endtask
endmodule

// ==== flag_bank_asserts.sv ====
// Purpose: Temporal checks on the flag bank ports
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to the top module after the checker
`timescale 1ns/1ps
module flag_bank_asserts (
    // Clock and reset
    input wire logic                         SYS_CLK,
    input wire logic                         RST_N,
    // Bus
    input wire logic                         HSEL,
    input wire logic [31:0]                  HADDR,
    input wire logic [1:0]                   HTRANS,
    input wire logic                         HWRITE,
    input wire logic                         HREADY,
    // Peripheral side
    input wire flag_bank_pkg::events_s       EVENTS,
    input wire flag_bank_pkg::async_state_s  ASYNC_STATE,
    input wire flag_bank_pkg::capcomp_mode_e CAPCOMP_ONE_MODE,
    input wire flag_bank_pkg::capcomp_mode_e CAPCOMP_TWO_MODE,
    input wire logic                         ZERO_CROSS_PIN,
    // Flags
    input wire flag_bank_pkg::flags_s        FLAGS,
    input wire logic                         WAKE_REQUEST
);
    localparam logic [31:0] GATE_ADDR = {18'h0_0000, flag_bank_pkg::IDX_CELL_GATE, 2'b00};
    logic       gate_wr_q;
    logic       gate_wr_d;
    logic [7:0] tim_evt;
    assign gate_wr_d = HSEL && HREADY && HTRANS[1] && HWRITE && (HADDR == GATE_ADDR);
    assign tim_evt = {2'b00, EVENTS.short_timer_match[2], EVENTS.long_timer_overflow[2],
                      EVENTS.short_timer_match[1], EVENTS.long_timer_overflow[1],
                      EVENTS.short_timer_match[0], EVENTS.long_timer_overflow[0]};
    // Write data phase to the gate register: the only cycle its flags may drop
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            gate_wr_q <= 1'b0;
        end else if (HREADY) begin
            gate_wr_q <= gate_wr_d;
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    chk_switch_sets: assert property (EVENTS.clock_switch_ready |=> FLAGS.clock_conv[6])
        else $error("clock switch flag not set");
    chk_switch_no_wake: assert property ((FLAGS.clock_conv == 8'h40 &&
        FLAGS[39:0] == '0) |-> !WAKE_REQUEST) else $error("clock switch flag alone requests wake");
    chk_conv_sets: assert property ((EVENTS.conv_threshold ||
        EVENTS.conv_done) |=> (FLAGS.clock_conv[1:0] & $past({EVENTS.conv_threshold, EVENTS.conv_done}))
        == $past({EVENTS.conv_threshold, EVENTS.conv_done})) else $error("converter flag");
    chk_timer_sets: assert property ((tim_evt != 8'h00)
        |=> (FLAGS.timer & $past(tim_evt)) == $past(tim_evt)) else $error("timer flag");
    chk_serial_levels: assert property ($past(RST_N) |-> FLAGS.serial[7:4] ==
        $past({ASYNC_STATE.rx_full[1], ASYNC_STATE.tx_empty[1],
               ASYNC_STATE.rx_full[0], ASYNC_STATE.tx_empty[0]})) else $error("serial level");
    chk_capture_mode: assert property ((CAPCOMP_ONE_MODE == flag_bank_pkg::CC_CAPTURE
        && EVENTS.capture_event[0]) |=> FLAGS.cell_capture[0]) else $error("capture flag");
    chk_compare_mode: assert property ((CAPCOMP_TWO_MODE == flag_bank_pkg::CC_COMPARE
        && EVENTS.compare_event[1]) |=> FLAGS.cell_capture[1]) else $error("compare flag");
    chk_pwm_unused: assert property ((CAPCOMP_TWO_MODE == flag_bank_pkg::CC_PWM
        && !FLAGS.cell_capture[1]) |=> !FLAGS.cell_capture[1]) else $error("pwm flag set");
    chk_gate_sticky: assert property (!gate_wr_q |=>
        (FLAGS.cell_gate & $past(FLAGS.cell_gate)) == $past(FLAGS.cell_gate))
        else $error("gate register flag dropped without a write");
    chk_zero_cross: assert property (($past(RST_N) && $changed(ZERO_CROSS_PIN))
        |-> ##[1:5] FLAGS.analog[6]) else $error("zero cross flag late");

    cover property (EVENTS.conv_done);
    cover property (gate_wr_q);
    cover property (CAPCOMP_ONE_MODE == flag_bank_pkg::CC_PWM && EVENTS.capture_event[0]);
endmodule

bind flag_bank_top flag_bank_asserts chk (.SYS_CLK, .RST_N, .HSEL, .HADDR, .HTRANS, .HWRITE,
    .HREADY, .EVENTS, .ASYNC_STATE, .CAPCOMP_ONE_MODE, .CAPCOMP_TWO_MODE, .ZERO_CROSS_PIN,
    .FLAGS, .WAKE_REQUEST);

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the interrupt flag bank
// Assumes: Zero-wait slave; bus signals change just after a rising edge
// Notes:   POS maps each event bit to its position in the flag vector
`timescale 1ns/1ps
module tb_top;
    localparam logic [31:0] CAP = {18'h0_0000, flag_bank_pkg::IDX_CELL_CAPTURE, 2'b00};
    localparam logic [31:0] BUF = {18'h0_0000, flag_bank_pkg::IDX_ASYNC_BUF, 2'b00};
    localparam int POS [32] = '{0, 1, 0, 1, 12, 13, 14, 15, 4, 5, 6, 7, 8, 9, 10, 16, 18, 20,
                                17, 19, 21, 24, 26, 25, 27, -1, -1, -1, 39, 40, 41, 46};
    logic                         SYS_CLK, RST_N, HSEL, HWRITE, HREADYOUT, HRESP, WAKE_REQUEST;
    logic                         ZERO_CROSS_PIN;
    logic [31:0]                  HADDR, HWDATA, HRDATA;
    logic [1:0]                   HTRANS, ASYNC_RX_READ, ASYNC_TX_WRITE, COMPARATOR_PIN;
    logic [2:0]                   HSIZE;
    flag_bank_pkg::events_s       EVENTS;
    flag_bank_pkg::async_state_s  ASYNC_STATE;
    flag_bank_pkg::capcomp_mode_e CAPCOMP_ONE_MODE, CAPCOMP_TWO_MODE;
    flag_bank_pkg::flags_s        FLAGS;
    int                           n_mismatch = 0;
    int                           comparisons = 0;

    flag_bank_top dut (.SYS_CLK, .RST_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
        .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .EVENTS, .ASYNC_STATE,
        .CAPCOMP_ONE_MODE, .CAPCOMP_TWO_MODE, .ZERO_CROSS_PIN, .COMPARATOR_PIN,
        .ASYNC_RX_READ, .ASYNC_TX_WRITE, .FLAGS, .WAKE_REQUEST);
    periph_model src (.clk(SYS_CLK), .rx_read(ASYNC_RX_READ), .tx_write(ASYNC_TX_WRITE),
        .events(EVENTS), .async_state(ASYNC_STATE), .zero_cross(ZERO_CROSS_PIN),
        .comparator(COMPARATOR_PIN));

    initial begin
        SYS_CLK = 1'b0;
        forever #50 SYS_CLK = ~SYS_CLK;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic wrap_up;
        $display("Counts: comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // A bus that never answers ends the run rather than hanging it
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 64);
        if (HREADYOUT !== 1'b1) begin
            check({47'h0, HREADYOUT}, 48'h1);
            wrap_up();
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge SYS_CLK);
        HSEL <= 1'b1;
        HTRANS <= 2'b10;
        HADDR <= addr;
        HWRITE <= wr;
        wait_ready();
        HTRANS <= 2'b00;
        HWDATA <= wd;
        wait_ready();
        rd = HRDATA;
        HSEL <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] addr, input logic [31:0] wd);
        logic [31:0] rd;
        bus(1'b1, addr, wd, rd);
    endtask
    task automatic rd_chk(input logic [31:0] addr, input logic [7:0] exp);
        logic [31:0] rd;
        bus(1'b0, addr, 32'h0000_0000, rd);
        check({16'h0000, rd}, {40'h00_0000_0000, exp});
    endtask
    task automatic do_reset;
        RST_N <= 1'b0;
        repeat (12) @(posedge SYS_CLK);
        RST_N <= 1'b1;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic test_reset;
        for (int r = 0; r < 7; r++) begin
            rd_chk(CAP + 32'h0000_0004 - 32'(4 * r), 8'h00);
        end
        $display("test_reset done");
    endtask
    // Every event bit that maps to a flag, alone, then a clearing write; serial levels stay low here
    task automatic test_events;
        int p;
        for (int k = 0; k < 32; k++) begin
            p = POS[k];
            if (p >= 0) begin
                CAPCOMP_ONE_MODE <= (k < 2) ? flag_bank_pkg::CC_COMPARE : flag_bank_pkg::CC_CAPTURE;
                CAPCOMP_TWO_MODE <= (k < 2) ? flag_bank_pkg::CC_COMPARE : flag_bank_pkg::CC_CAPTURE;
                src.pulse(flag_bank_pkg::events_s'(32'h1 << k));
                @(posedge SYS_CLK);
                check(FLAGS, 48'h1 << p);
                check({47'h0, WAKE_REQUEST}, {47'h0, k != 31});
                rd_chk(CAP - 32'(4 * (p / 8)), 8'h01 << (p % 8));
                wr(CAP - 32'(4 * (p / 8)), ~(32'h1 << (p % 8)));
                rd_chk(CAP - 32'(4 * (p / 8)), 8'h00);
            end
        end
        $display("test_events done");
    endtask
    task automatic test_modes;
        flag_bank_pkg::capcomp_mode_e m [2] = '{flag_bank_pkg::CC_PWM, flag_bank_pkg::CC_OFF};
        for (int i = 0; i < 2; i++) begin
            CAPCOMP_ONE_MODE <= m[i];
            CAPCOMP_TWO_MODE <= m[i];
            src.pulse(flag_bank_pkg::events_s'(32'h0000_000F));
            @(posedge SYS_CLK);
            check(FLAGS, 48'h0);
        end
        $display("test_modes done");
    endtask
    task automatic test_pins;
        for (int i = 0; i < 2; i++) begin
            src.toggle_pins(3'b111);
            repeat (6) @(posedge SYS_CLK);
            rd_chk(CAP - 32'h0000_0010, 8'h43);
            wr(CAP - 32'h0000_0010, 32'h0000_0000);
        end
        $display("test_pins done");
    endtask
    task automatic test_async;
        logic [31:0] rd;
        src.set_levels(2'b01, 2'b10);
        rd_chk(CAP - 32'h0000_000C, 8'h60);
        wr(CAP - 32'h0000_000C, 32'h0000_0000);
        rd_chk(CAP - 32'h0000_000C, 8'h60);
        bus(1'b0, BUF, 32'h0000_0001, rd);
        check({16'h0000, rd}, 48'h0);
        rd_chk(CAP - 32'h0000_000C, 8'h40);
        wr(BUF, 32'h0000_0002);
        rd_chk(CAP - 32'h0000_000C, 8'h00);
        $display("test_async done");
    endtask
    // The event lands in the data phase of the clearing write
    task automatic test_set_wins;
        src.pulse(flag_bank_pkg::events_s'(32'h0004_0000));
        fork
            wr(CAP - 32'h0000_0008, 32'h0000_0000);
            begin
                @(posedge SYS_CLK);
                src.pulse(flag_bank_pkg::events_s'(32'h0004_0000));
            end
        join
        rd_chk(CAP - 32'h0000_0008, 8'h02);
        src.pulse(flag_bank_pkg::events_s'(32'h0003_8000));
        do_reset();
        $display("test_set_wins done");
    endtask

    initial begin
        RST_N = 1'b0;
        HSEL = 1'b0;
        HADDR = 32'h0000_0000;
        HTRANS = 2'b00;
        HWRITE = 1'b0;
        HSIZE = 3'b010;
        HWDATA = 32'h0000_0000;
        CAPCOMP_ONE_MODE = flag_bank_pkg::CC_OFF;
        CAPCOMP_TWO_MODE = flag_bank_pkg::CC_OFF;
        do_reset();
        test_reset();
        test_events();
        test_modes();
        test_pins();
        test_async();
        test_set_wins();
        test_reset();
        wrap_up();
    end
endmodule
